// ---- core/efr_regs.svh ----
`ifndef EFR_REGS_SVH
`define EFR_REGS_SVH

// ************************************************
// register byte offsets
// ************************************************
`define EFR_OFF_PUBCFG 12'h000
`define EFR_OFF_SUBCFG 12'h004
`define EFR_OFF_TRIGCTL 12'h008
`define EFR_OFF_SWTRIG 12'h00C
`define EFR_OFF_GRP0IDX 12'h010
`define EFR_OFF_GRP1IDX 12'h014
`define EFR_OFF_RAWSTAT 12'h018

// ************************************************
// reset values
// ************************************************
`define EFR_RST_PUBCFG 16'h0000
`define EFR_RST_SUBCFG 4'h0
`define EFR_RST_TRIGCTL 12'h000

// ************************************************
// field positions
// ************************************************
`define EFR_POS_SUB1SEL 2
`define EFR_POS_TSEL1 4
`define EFR_POS_TSEL2 8
`define EFR_POS_IDXVLD 8
`define EFR_POS_RAW_SUB1 1
`define EFR_POS_RAW_LINE0 4
`define EFR_POS_RAW_LINE1 5

// ************************************************
// group indices and trigger-select codes
// ************************************************
`define EFR_GRP0_SUB0 3'h4
`define EFR_GRP0_SUB1 3'h5
`define EFR_TSEL_SW 4'h0
`define EFR_TSEL_SUB0 4'h1
`define EFR_TSEL_SUB1 4'h2
`define EFR_TSEL_FIRSTPUB 4'h3
`define EFR_TSEL_LAST 4'hD

`endif

// ---- core/efr_pkg.sv ----
package efr_pkg;

    // ************************************************
    // types
    // ************************************************
    typedef enum logic [1:0] {
        EFR_CH_NONE,
        EFR_CH_ONE,
        EFR_CH_TWO,
        EFR_CH_SPLIT
    } efr_chan_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } efr_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } efr_apb_rsp_s;

    typedef logic [3:0] efr_tsel_t;
    typedef logic [2:0] efr_idx_t;

endpackage

// ---- core/efr_int_group.sv ----
`timescale 1ns/100ps
module efr_int_group
    import efr_pkg::*;
(
    // pending sources by group index
    input wire logic [6:0] pend,
    // shared line and reported index
    output logic lineAct,
    output efr_idx_t lowIdx
);

    // ************************************************
    // lowest pending index
    // ************************************************
    function automatic efr_idx_t lowestSet(input logic [6:0] v);
        efr_idx_t r;
        r = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    assign lineAct = |pend;
    assign lowIdx = lowestSet(pend);

endmodule

// ---- core/efr_dma_trig.sv ----
`timescale 1ns/100ps
`include "efr_regs.svh"
module efr_dma_trig
    import efr_pkg::*;
(
    // trigger-select field of one channel
    input wire efr_tsel_t tsel,
    // candidate sources by select code
    input wire logic [13:0] src,
    // selected trigger
    output logic trig
);

    wire logic tselValid;
    wire logic [15:0] srcPad;

    assign tselValid = (tsel <= `EFR_TSEL_LAST);
    // codes above the last publisher select nothing
    assign srcPad = {2'h0, src};
    assign trig = tselValid & srcPad[tsel];

endmodule

// ---- core/efr_top.sv ----
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
`include "efr_regs.svh"

// Operation
// - events travel from publishers to subscribers over fixed and programmed routes.
// - static route carries peripheral events to the processor as interrupt lines.
// - DMA route turns peripheral events into DMA transfer triggers.
// - generic route hands a publisher event to another peripheral subscriber port.
// - generic channel is one-to-one, or splitter to exactly two receivers.
// - channel code 0 none, 1 and 2 one-to-one, 3 splitter.
// - trigger select 0 software, 1-2 generic subscribers, 3-13 publisher outputs.
// - line 0 and line 1 are shared with group indices; others dedicated.
// - each DMA channel has a trigger-select field choosing its trigger.
module efr_top
    import efr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire efr_apb_req_s apbReq,
    output efr_apb_rsp_s apbRsp,
    // generic and DMA publishers
    input wire logic [7:0] pubEvent,
    input wire logic [10:0] dmaPub,
    // shared line sources
    input wire logic windowedWatchdogIrq,
    input wire logic debugSubsystemIrq,
    input wire logic flashControllerIrq,
    input wire logic systemControllerIrq,
    input wire logic portAPinsIrq,
    input wire logic portBPinsIrq,
    input wire logic randomSourceIrq,
    // dedicated line sources
    input wire logic [31:2] dedIrq,
    // routed outputs
    output logic [31:0] irqLine,
    output logic [2:0] dmaTrig,
    output logic [3:0] periphSub
);

    // ************************************************
    // declarations
    // ************************************************
    logic [15:0] pubCfg_q;
    logic [3:0] subCfg_q;
    logic [11:0] trigCtl_q;
    logic [2:0] swTrig_q;
    logic sub0Pend_q;
    logic sub1Pend_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] irqLine_q;
    logic [2:0] dmaTrig_q;
    logic [3:0] periphSub_q;
    logic [31:0] rdData;
    logic mapped;
    logic [3:1] chanEvt;
    logic [2:0] chTrig;
    logic grp0Act;
    logic grp1Act;
    efr_idx_t grp0Idx;
    efr_idx_t grp1Idx;

    // ************************************************
    // functions
    // ************************************************
    function automatic logic chanHit(input logic [15:0] cfg, input logic [7:0] ev,
                                     input efr_chan_e code);
        logic r;
        r = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (ev[i] && (efr_chan_e'(cfg[2*i +: 2]) == code)) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    function automatic logic chanOf(input logic [1:0] sel, input logic [3:1] evt);
        logic r;
        r = 1'b0;
        if (efr_chan_e'(sel) != EFR_CH_NONE) begin
            r = evt[sel];
        end
        return r;
    endfunction

    // ************************************************
    // bus decode
    // ************************************************
    wire logic setupAcc = apbReq.psel & apbReq.penable & ~pready_q;
    wire logic xferDone = apbReq.psel & apbReq.penable & pready_q;
    wire logic wrDone = xferDone & apbReq.pwrite & ~pslverr_q;
    wire logic rdDone = xferDone & ~apbReq.pwrite;
    wire logic selPub = (apbReq.paddr == `EFR_OFF_PUBCFG);
    wire logic selSub = (apbReq.paddr == `EFR_OFF_SUBCFG);
    wire logic selTrig = (apbReq.paddr == `EFR_OFF_TRIGCTL);
    wire logic selSw = (apbReq.paddr == `EFR_OFF_SWTRIG);
    wire logic selGrp0 = (apbReq.paddr == `EFR_OFF_GRP0IDX);
    wire logic selGrp1 = (apbReq.paddr == `EFR_OFF_GRP1IDX);
    wire logic selRaw = (apbReq.paddr == `EFR_OFF_RAWSTAT);

    always_comb begin
        rdData = 32'h0000_0000;
        mapped = 1'b1;
        if (selPub) begin
            rdData = {16'h0000, pubCfg_q};
        end else if (selSub) begin
            rdData = {28'h000_0000, subCfg_q};
        end else if (selTrig) begin
            rdData = {20'h0_0000, trigCtl_q};
        end else if (selSw) begin
            rdData = 32'h0000_0000;
        end else if (selGrp0) begin
            rdData = {23'h00_0000, grp0Act, 5'h00, grp0Idx};
        end else if (selGrp1) begin
            rdData = {23'h00_0000, grp1Act, 5'h00, grp1Idx};
        end else if (selRaw) begin
            rdData = {26'h000_0000, grp1Act, grp0Act, 2'h0, sub1Pend_q, sub0Pend_q};
        end else begin
            mapped = 1'b0;
        end
    end

    // ************************************************
    // bus slave
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setupAcc;
            pslverr_q <= setupAcc & ~mapped;
            if (setupAcc && !apbReq.pwrite) begin
                prdata_q <= rdData;
            end
        end
    end

    // ************************************************
    // configuration registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pubCfg_q <= `EFR_RST_PUBCFG;
            subCfg_q <= `EFR_RST_SUBCFG;
            trigCtl_q <= `EFR_RST_TRIGCTL;
        end else if (wrDone) begin
            if (selPub) begin
                pubCfg_q <= apbReq.pwdata[15:0];
            end
            if (selSub) begin
                subCfg_q <= apbReq.pwdata[3:0];
            end
            if (selTrig) begin
                trigCtl_q <= apbReq.pwdata[11:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            swTrig_q <= 3'h0;
        end else begin
            swTrig_q <= (wrDone && selSw) ? apbReq.pwdata[2:0] : 3'h0;
        end
    end

    // ************************************************
    // generic routes
    // ************************************************
    assign chanEvt[1] = chanHit(pubCfg_q, pubEvent, EFR_CH_ONE);
    assign chanEvt[2] = chanHit(pubCfg_q, pubEvent, EFR_CH_TWO);
    assign chanEvt[3] = chanHit(pubCfg_q, pubEvent, EFR_CH_SPLIT);

    wire logic [1:0] sub0Sel = subCfg_q[1:0];
    wire logic [1:0] sub1Sel = subCfg_q[`EFR_POS_SUB1SEL +: 2];
    wire logic sub0Split = (efr_chan_e'(sub0Sel) == EFR_CH_SPLIT);
    wire logic sub1Split = (efr_chan_e'(sub1Sel) == EFR_CH_SPLIT);
    wire logic sub1Blocked = (sub1Sel == sub0Sel) && !sub1Split;
    wire logic sub0Evt = chanOf(sub0Sel, chanEvt);
    wire logic sub1Evt = chanOf(sub1Sel, chanEvt) & ~sub1Blocked;
    wire logic ch1Claimed = (sub0Sel == 2'h1) || (sub1Sel == 2'h1);
    wire logic ch2Claimed = (sub0Sel == 2'h2) || (sub1Sel == 2'h2);
    wire logic [3:0] periphNext = {
        chanEvt[3] & ~sub0Split & ~sub1Split,
        chanEvt[3] & ~(sub0Split & sub1Split),
        chanEvt[2] & ~ch2Claimed,
        chanEvt[1] & ~ch1Claimed
    };

    // ************************************************
    // DMA triggers
    // ************************************************
    for (genvar c = 0; c < 3; c++) begin : gTrig
        efr_dma_trig uTrig (
            .tsel(trigCtl_q[4*c +: 4]),
            .src({dmaPub, sub1Evt, sub0Evt, swTrig_q[c]}),
            .trig(chTrig[c])
        );
    end

    // ************************************************
    // shared interrupt lines
    // ************************************************
    wire logic clrSub0 = rdDone && selGrp0 && (prdata_q[2:0] == `EFR_GRP0_SUB0);
    wire logic clrSub1 = rdDone && selGrp0 && (prdata_q[2:0] == `EFR_GRP0_SUB1);
    wire logic [6:0] pend0 = {systemControllerIrq, sub1Pend_q, sub0Pend_q,
                              flashControllerIrq, debugSubsystemIrq, 1'b0,
                              windowedWatchdogIrq};
    wire logic [6:0] pend1 = {1'b0, randomSourceIrq, 3'h0, portBPinsIrq,
                              portAPinsIrq};

    always_ff @(posedge clk) begin
        if (rst) begin
            sub0Pend_q <= 1'b0;
            sub1Pend_q <= 1'b0;
        end else begin
            sub0Pend_q <= sub0Evt | (sub0Pend_q & ~clrSub0);
            sub1Pend_q <= sub1Evt | (sub1Pend_q & ~clrSub1);
        end
    end

    efr_int_group uGrp0 (
        .pend(pend0),
        .lineAct(grp0Act),
        .lowIdx(grp0Idx)
    );

    efr_int_group uGrp1 (
        .pend(pend1),
        .lineAct(grp1Act),
        .lowIdx(grp1Idx)
    );

    // ************************************************
    // output registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            irqLine_q <= 32'h0000_0000;
            dmaTrig_q <= 3'h0;
            periphSub_q <= 4'h0;
        end else begin
            irqLine_q <= {dedIrq, grp1Act, grp0Act};
            dmaTrig_q <= chTrig;
            periphSub_q <= periphNext;
        end
    end

    assign irqLine = irqLine_q;
    assign dmaTrig = dmaTrig_q;
    assign periphSub = periphSub_q;
    assign apbRsp = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sSwWrite0;
        wrDone && selSw && apbReq.pwdata[0] && (trigCtl_q[3:0] == 4'h0);
    endsequence

    sequence sSub0Pending;
        sub0Evt ##1 sub0Pend_q;
    endsequence

    AST_STATIC_LINE: assert property (##1 irqLine_q[31:2] == $past(dedIrq))
        else $error("dedicated line does not follow its source");
    AST_SW_TRIG: assert property (sSwWrite0 |-> ##2 dmaTrig_q[0])
        else $error("software trigger did not reach channel 0");
    AST_PUB_TRIG: assert property ((trigCtl_q[11:8] == 4'h3) && dmaPub[0]
                                   |=> dmaTrig_q[2])
        else $error("publisher 3 did not trigger channel 2");
    AST_SUB_TRIG: assert property ((trigCtl_q[3:0] == 4'h1) && sub0Evt
                                   |=> dmaTrig_q[0])
        else $error("subscriber port zero did not trigger channel 0");
    AST_TSEL_RANGE: assert property ((trigCtl_q[11:8] > 4'hD) |=> !dmaTrig_q[2])
        else $error("out-of-range select raised a trigger");
    AST_GEN_CH1: assert property (chanEvt[1] && (subCfg_q == 4'h0)
                                  |=> periphSub_q[0])
        else $error("channel 1 event lost");
    AST_ONE_RECV: assert property (periphSub_q[0] |-> $past(!ch1Claimed))
        else $error("one-to-one channel reached two receivers");
    AST_SPLIT_TWO: assert property ($countones({periphNext[3:2], sub0Split & sub0Evt,
                                    sub1Split & sub1Evt}) <= 2)
        else $error("splitter reached more than two receivers");
    AST_CHAN_NONE: assert property ((pubCfg_q == 16'h0000) |-> (chanEvt == 3'h0))
        else $error("code 0 publisher drove a channel");
    AST_GRP1_IDX: assert property (portBPinsIrq && !portAPinsIrq
                                   |-> grp1Idx == 3'h1 ##1 irqLine_q[1])
        else $error("line 1 index or level wrong");
    AST_LOWEST: assert property (windowedWatchdogIrq |-> grp0Idx == 3'h0)
        else $error("line 0 did not report lowest index");
    AST_STICKY: assert property (sSub0Pending |=> irqLine_q[0])
        else $error("pending subscriber did not hold line 0");

endmodule

// ---- verification/efr_pub_model.sv ----
`timescale 1ns/100ps
module efr_pub_model
    import efr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // requests from the bench
    input wire logic [7:0] fireGen,
    input wire logic [10:0] fireDma,
    // publisher outputs
    output logic [7:0] pubEvent,
    output logic [10:0] dmaPub
);
    // ************************************************
    // publishers: one-cycle pulses, idle low
    // ************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            pubEvent <= 8'h00;
            dmaPub <= 11'h000;
        end else begin
            pubEvent <= fireGen;
            dmaPub <= fireDma;
        end
    end
endmodule

// ---- verification/efr_top_test.sv ----
`timescale 1ns/100ps
`include "efr_regs.svh"
module efr_top_test
    import efr_pkg::*;
;
    // ************************************************
    // signals
    // ************************************************
    logic clk, rst, wdIrq, dbgIrq, flIrq, sysIrq, paIrq, pbIrq, rnIrq;
    efr_apb_req_s apbReq;
    efr_apb_rsp_s apbRsp;
    logic [7:0] pubEvent, fireGen;
    logic [10:0] dmaPub, fireDma;
    logic [31:2] dedIrq;
    logic [31:0] irqLine, rdv;
    logic [2:0] dmaTrig, seen;
    logic [3:0] periphSub;
    logic erv;
    int n_mismatch, n_compared;
    int rowPub[5] = '{0, 1, 2, 7, 7};
    int rowCode[5] = '{1, 2, 3, 0, 3};
    logic [3:0] rowSub[5] = '{4'h1, 4'h2, 4'hC, 4'h0, 4'hC};

    efr_pub_model i_efr_pub_model (.clk(clk), .rst(rst), .fireGen(fireGen),
        .fireDma(fireDma), .pubEvent(pubEvent), .dmaPub(dmaPub));
    efr_top i_efr_top (.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .pubEvent(pubEvent), .dmaPub(dmaPub), .windowedWatchdogIrq(wdIrq),
        .debugSubsystemIrq(dbgIrq), .flashControllerIrq(flIrq),
        .systemControllerIrq(sysIrq), .portAPinsIrq(paIrq), .portBPinsIrq(pbIrq),
        .randomSourceIrq(rnIrq), .dedIrq(dedIrq), .irqLine(irqLine),
        .dmaTrig(dmaTrig), .periphSub(periphSub));

    // ************************************************
    // tasks
    // ************************************************
    task print_verdict();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (apbRsp.pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            print_verdict();
        end else begin
            rdv = apbRsp.prdata;
            erv = apbRsp.pslverr;
            apbReq <= '0;
        end
    endtask

    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdv, e);
    endtask

    task ev(input logic [7:0] g, input logic [10:0] m);
        @(posedge clk);
        fireGen <= g;
        fireDma <= m;
        @(posedge clk);
        fireGen <= 8'h00;
        fireDma <= 11'h000;
        @(posedge clk);
        #1;
    endtask

    task do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask

    // ************************************************
    // clock and sequence
    // ************************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #2000000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        {rst, wdIrq, dbgIrq, flIrq, sysIrq, paIrq, pbIrq, rnIrq} = 8'h80;
        apbReq = '0;
        fireGen = 8'h00;
        fireDma = 11'h000;
        dedIrq = '0;
        n_mismatch = 0;
        n_compared = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(irqLine, 32'h0);
        chk({25'h0, dmaTrig, periphSub}, 32'h0);
        rdc(`EFR_OFF_PUBCFG, 32'h0);
        rdc(`EFR_OFF_TRIGCTL, 32'h0);
        apb(1'b0, 12'h01C, 32'h0);
        chk({erv, rdv[30:0]}, 32'h80000000);
        // generic routes by table
        for (int r = 0; r < 5; r++) begin
            apb(1'b1, `EFR_OFF_PUBCFG, rowCode[r] << (2 * rowPub[r]));
            ev(8'h01 << rowPub[r], 11'h000);
            chk(periphSub, rowSub[r]);
        end
        // trigger select codes on channel 2
        for (int t = 3; t < 16; t++) begin
            apb(1'b1, `EFR_OFF_TRIGCTL, t << `EFR_POS_TSEL2);
            ev(8'h00, (t < 14) ? (11'h001 << (t - 3)) : 11'h7FF);
            chk(dmaTrig, (t < 14) ? 3'h4 : 3'h0);
        end
        // software trigger
        apb(1'b1, `EFR_OFF_TRIGCTL, 32'h0);
        apb(1'b1, `EFR_OFF_SWTRIG, 32'h5);
        seen = 3'h0;
        repeat (4) begin
            @(posedge clk);
            #1;
            seen = seen | dmaTrig;
        end
        chk(seen, 3'h5);
        rdc(`EFR_OFF_SWTRIG, 32'h0);
        // subscriber ports claim channels 1 and 2
        apb(1'b1, `EFR_OFF_SUBCFG, 32'h9);
        apb(1'b1, `EFR_OFF_PUBCFG, 32'h9);
        apb(1'b1, `EFR_OFF_TRIGCTL, 32'h21);
        ev(8'h03, 11'h000);
        chk(periphSub, 4'h0);
        chk(dmaTrig, 3'h3);
        rdc(`EFR_OFF_RAWSTAT, 32'h13);
        chk(irqLine[0], 1'b1);
        rdc(`EFR_OFF_GRP0IDX, 32'h104);
        rdc(`EFR_OFF_GRP0IDX, 32'h105);
        rdc(`EFR_OFF_GRP0IDX, 32'h000);
        // shared and dedicated lines
        {wdIrq, flIrq, sysIrq, pbIrq, rnIrq} <= 5'h1F;
        dedIrq[9] <= 1'b1;
        rdc(`EFR_OFF_GRP0IDX, 32'h100);
        rdc(`EFR_OFF_GRP1IDX, 32'h101);
        chk(irqLine, 32'h203);
        wdIrq <= 1'b0;
        rdc(`EFR_OFF_GRP0IDX, 32'h103);
        {flIrq, sysIrq, pbIrq, rnIrq} <= 4'h0;
        dedIrq[9] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(irqLine, 32'h0);
        @(posedge clk);
        {dbgIrq, paIrq} <= 2'h3;
        rdc(`EFR_OFF_GRP0IDX, 32'h102);
        rdc(`EFR_OFF_GRP1IDX, 32'h100);
        // reset in mid-run, sources still raised
        do_reset();
        #1;
        chk(irqLine, 32'h0);
        chk({25'h0, dmaTrig, periphSub}, 32'h0);
        @(posedge clk);
        #1;
        chk(irqLine, 32'h3);
        @(posedge clk);
        {dbgIrq, paIrq} <= 2'h0;
        rdc(`EFR_OFF_SUBCFG, 32'h0);
        rdc(`EFR_OFF_PUBCFG, 32'h0);
        print_verdict();
    end
endmodule
